// file: verilog/quad_uart_pins_pkg.sv
// Purpose: Shared constants and carriers for the quad UART pin logic
// Assumes: Four channels, bit positions as used by the control registers
// Notes: Register contents arrive as plain ports, no bus
package quad_uart_pins_pkg;
   localparam int NUM_CH = 4;
   localparam int MCR_RTS_BIT = 1;
   localparam int MCR_LOOP_BIT = 4;
   localparam int EFR_AUTO_RTS_BIT = 6;
   localparam int ADDR_W = 5;
   localparam logic [7:0] MCR_RESET = 8'h00;
   localparam logic [7:0] EFR_RESET = 8'h00;
   localparam logic LINE_IDLE = 1'b1;

   typedef struct packed {
      logic [7:0] modemCtrl;
      logic [7:0] enhFeature;
      logic txEnable;
      logic txData;
      logic rxHasData;
      logic txHasSpace;
      logic autoRtsReady;
   } chan_ctrl_t;

   typedef struct packed {
      logic rtsN;
      logic txPin;
      logic rxToCore;
   } chan_pins_t;

   typedef struct packed {
      logic sel;
      logic [ADDR_W-1:0] addr;
      logic rdNotWr;
   } host_req_t;
endpackage

// file: verilog/quad_uart_pins.sv
// Purpose: Pin signalling of a four-channel UART: request-to-send, strobe, TX/RX, readies
// Assumes: Inputs synchronous to sys_clk; per-channel core supplies register bits and status
// Notes: All outputs registered, so pins lag the core state by one cycle
`timescale 1ns/1ns
module quad_uart_pins #(
   parameter int CHANNELS = quad_uart_pins_pkg::NUM_CH
) (
   // Clock, reset, enable
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic clkEn,
   // Per-channel core side
   input quad_uart_pins_pkg::chan_ctrl_t chanCtrl [CHANNELS],
   output quad_uart_pins_pkg::chan_pins_t chanPins [CHANNELS],
   // Serial line pins
   input wire logic [CHANNELS-1:0] rxPin,
   // Host bus and auto-RTS hold
   input wire logic altHostMode,
   input quad_uart_pins_pkg::host_req_t hostReq,
   output logic hostRdStrobe,
   output logic hostWrStrobe,
   output logic [quad_uart_pins_pkg::ADDR_W-1:0] regAddrLines,
   output logic [CHANNELS-1:0] autoRtsHold,
   // Combined readies
   output logic rx_ready_combined_n,
   output logic tx_ready_combined_n
);
   import quad_uart_pins_pkg::*;

   // Host strobe state
   logic rdStb_reg;
   logic rdStb_next;
   logic wrStb_reg;
   logic wrStb_next;
   logic hostSel;
   logic hostRead;

   // Register address state
   logic [ADDR_W-1:0] addr_reg;
   logic [ADDR_W-1:0] addr_next;

   // Combined readiness state
   logic rxRdyN_reg;
   logic rxRdyN_next;
   logic txRdyN_reg;
   logic txRdyN_next;
   wire logic [CHANNELS-1:0] rxAny;
   wire logic [CHANNELS-1:0] txAny;
   wire logic [CHANNELS-1:0] holdAll;

   genvar g;
   generate
      for (g = 0; g < CHANNELS; g++) begin : gCh
         logic loopOn;
         logic txIdle;
         logic rtsN_reg;
         logic rtsN_next;
         logic txPin_reg;
         logic txPin_next;
         logic rxCore_reg;
         logic rxCore_next;
         logic hold_reg;
         logic hold_next;

         // Loop-back takes the line away from the far end in both directions
         assign loopOn = chanCtrl[g].modemCtrl[MCR_LOOP_BIT];
         assign txIdle = loopOn | ~chanCtrl[g].txEnable;

         // Request-to-send is the control bit inverted
         always_comb begin
            rtsN_next = ~chanCtrl[g].modemCtrl[MCR_RTS_BIT];
         end

         always_ff @(posedge sys_clk or negedge rst_n) begin
            if (!rst_n) begin
               rtsN_reg <= 1'b1;
            end else if (clkEn) begin
               rtsN_reg <= rtsN_next;
            end
         end

         // Disabled or looped transmitter parks the line at idle
         always_comb begin
            if (txIdle) begin
               txPin_next = LINE_IDLE;
            end else begin
               txPin_next = chanCtrl[g].txData;
            end
         end

         always_ff @(posedge sys_clk or negedge rst_n) begin
            if (!rst_n) begin
               txPin_reg <= LINE_IDLE;
            end else if (clkEn) begin
               txPin_reg <= txPin_next;
            end
         end

         // The far end idles high, so no glitch filter is needed on the pin
         always_comb begin
            if (loopOn) begin
               rxCore_next = chanCtrl[g].txData;
            end else begin
               rxCore_next = rxPin[g];
            end
         end

         always_ff @(posedge sys_clk or negedge rst_n) begin
            if (!rst_n) begin
               rxCore_reg <= LINE_IDLE;
            end else if (clkEn) begin
               rxCore_reg <= rxCore_next;
            end
         end

         // Hold off only under auto flow; manual mode leaves data flow alone
         always_comb begin
            hold_next = chanCtrl[g].enhFeature[EFR_AUTO_RTS_BIT]
                        & ~chanCtrl[g].autoRtsReady;
         end

         always_ff @(posedge sys_clk or negedge rst_n) begin
            if (!rst_n) begin
               hold_reg <= 1'b0;
            end else if (clkEn) begin
               hold_reg <= hold_next;
            end
         end

         assign chanPins[g] = '{rtsN: rtsN_reg, txPin: txPin_reg, rxToCore: rxCore_reg};
         assign rxAny[g] = chanCtrl[g].rxHasData;
         assign txAny[g] = chanCtrl[g].txHasSpace;
         assign holdAll[g] = hold_reg;
      end
   endgenerate

   // Outside alternate mode both the read and the write strobe are held low
   always_comb begin
      hostSel = altHostMode & hostReq.sel;
      hostRead = hostReq.rdNotWr;
      rdStb_next = hostSel & hostRead;
      wrStb_next = hostSel & ~hostRead;
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdStb_reg <= 1'b0;
         wrStb_reg <= 1'b0;
      end else if (clkEn) begin
         rdStb_reg <= rdStb_next;
         wrStb_reg <= wrStb_next;
      end
   end

   // Address lines keep the last selected register between accesses
   always_comb begin
      if (hostReq.sel) begin
         addr_next = hostReq.addr;
      end else begin
         addr_next = addr_reg;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         addr_reg <= '0;
      end else if (clkEn) begin
         addr_reg <= addr_next;
      end
   end

   // Wired-OR of the channels, kept active low to match the pins
   always_comb begin
      rxRdyN_next = ~(|rxAny);
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rxRdyN_reg <= 1'b1;
      end else if (clkEn) begin
         rxRdyN_reg <= rxRdyN_next;
      end
   end

   // Transmit side reports room, so it stays low until every channel is full
   always_comb begin
      txRdyN_next = ~(|txAny);
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         txRdyN_reg <= 1'b1;
      end else if (clkEn) begin
         txRdyN_reg <= txRdyN_next;
      end
   end

   assign hostRdStrobe = rdStb_reg;
   assign hostWrStrobe = wrStb_reg;
   assign regAddrLines = addr_reg;
   assign autoRtsHold = holdAll;
   assign rx_ready_combined_n = rxRdyN_reg;
   assign tx_ready_combined_n = txRdyN_reg;
endmodule // quad_uart_pins

// file: verification/quad_uart_pins_assertions.sv
// Purpose: Pin rule checker
// Assumes: Channel 0 stands for its siblings
// Notes: Outputs lag inputs by one enabled edge
`timescale 1ns/1ns
module quad_uart_pins_assertions
import quad_uart_pins_pkg::*;
#(parameter int CHANNELS = NUM_CH) (
   input wire logic sys_clk, rst_n, clkEn, altHostMode, hostRdStrobe, hostWrStrobe,
   input wire logic rx_ready_combined_n, tx_ready_combined_n,
   input host_req_t hostReq,
   input chan_ctrl_t chanCtrl [CHANNELS],
   input chan_pins_t chanPins [CHANNELS],
   input wire logic [CHANNELS-1:0] autoRtsHold);
   logic anyRx, anyTx;
   always_comb begin
      anyRx = 1'b0;
      anyTx = 1'b0;
      for (int i = 0; i < CHANNELS; i++) begin
         anyRx = anyRx | chanCtrl[i].rxHasData;
         anyTx = anyTx | chanCtrl[i].txHasSpace;
      end
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   a_rts_set: assert property (clkEn |=> chanPins[0].rtsN ==
      !$past(chanCtrl[0].modemCtrl[MCR_RTS_BIT])) else $error("rts");
   a_reset_high: assert property (disable iff (1'b0) !rst_n |->
      chanPins[0].rtsN && chanPins[0].txPin) else $error("reset");
   a_auto_hold: assert property (clkEn |=> autoRtsHold[0] == $past(
      chanCtrl[0].enhFeature[EFR_AUTO_RTS_BIT] && !chanCtrl[0].autoRtsReady)) else $error("hold");
   a_strobe_mode: assert property (clkEn && !altHostMode |=>
      !hostRdStrobe && !hostWrStrobe) else $error("strobe");
   a_strobe_dir: assert property (clkEn && altHostMode && hostReq.sel |=>
      hostRdStrobe == $past(hostReq.rdNotWr) && hostWrStrobe == !$past(hostReq.rdNotWr))
      else $error("dir");
   a_tx_quiet: assert property (clkEn && (chanCtrl[0].modemCtrl[MCR_LOOP_BIT] ||
      !chanCtrl[0].txEnable) |=> chanPins[0].txPin) else $error("tx");
   a_loop_route: assert property (clkEn && chanCtrl[0].modemCtrl[MCR_LOOP_BIT] |=>
      chanPins[0].rxToCore == $past(chanCtrl[0].txData)) else $error("loop");
   a_rx_ready: assert property (clkEn |=> rx_ready_combined_n == !$past(anyRx))
      else $error("rx_ready_combined_n");
   a_tx_ready: assert property (clkEn |=> tx_ready_combined_n == !$past(anyTx))
      else $error("tx_ready_combined_n");
endmodule // quad_uart_pins_assertions

// file: verification/quad_uart_far_model.sv
// Purpose: Remote serial party
// Assumes: It echoes what it hears
// Notes: Line starts high so reset sees idle
`timescale 1ns/1ns
module quad_uart_far_model (
   input wire logic sys_clk,
   input wire logic [3:0] txLine,
   output logic [3:0] rxLine = 4'hf);
   always @(posedge sys_clk) rxLine <= txLine;
endmodule // quad_uart_far_model

// file: verification/test_quad_uart_pins.sv
// Purpose: Bench for pin signalling
// Assumes: clkEn held high throughout
// Notes: Stimulus by NBA at rising edges
`timescale 1ns/1ns
module test_quad_uart_pins;
   import quad_uart_pins_pkg::*;
   logic sys_clk = 0, rst_n = 1, clkEn = 1, altHostMode = 0, rdS, wrS, rxN, txN;
   logic [3:0] rxPin, txLine, hold;
   logic [4:0] addr;
   chan_ctrl_t ctrl [NUM_CH] = '{default: '0};
   chan_pins_t pins [NUM_CH];
   host_req_t req = '0;
   int n_fail = 0, n_compared = 0;
   initial forever #50 sys_clk = ~sys_clk;
   assign txLine = {pins[3].txPin, pins[2].txPin, pins[1].txPin, pins[0].txPin};
   quad_uart_far_model far_u (.sys_clk(sys_clk), .txLine(txLine), .rxLine(rxPin));
   quad_uart_pins dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .clkEn(clkEn), .chanCtrl(ctrl),
      .chanPins(pins), .rxPin(rxPin), .altHostMode(altHostMode), .hostReq(req),
      .hostRdStrobe(rdS), .hostWrStrobe(wrS), .regAddrLines(addr), .autoRtsHold(hold),
      .rx_ready_combined_n(rxN), .tx_ready_combined_n(txN));
   task chk(input logic [7:0] seen, exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task give_verdict;
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task cyc; @(posedge sys_clk); #1; endtask
   task acc(input logic m, s, r, input logic [4:0] a, input logic er, ew,
      input logic [4:0] ea);
      @(posedge sys_clk);
      altHostMode <= m;
      req <= '{s, a, r};
      cyc;
      chk({rdS, wrS}, {er, ew});
      chk(addr, ea);
   endtask
   initial begin #100000; n_fail++; give_verdict; end
   initial begin
      rst_n <= 1'b0;
      repeat (10) @(posedge sys_clk);
      #1 chk({pins[0].rtsN, pins[1].txPin, rxN}, 3'h7);
      $display("reset test done");
      @(posedge sys_clk) rst_n <= 1;
      @(posedge sys_clk) ctrl[0].modemCtrl <= 8'h02;
      cyc;
      chk({pins[0].rtsN, pins[1].rtsN}, 2'h1);
      @(posedge sys_clk) ctrl[0].modemCtrl <= 8'h10;
      ctrl[0].enhFeature <= 8'h40;
      ctrl[0].txEnable <= 1;
      ctrl[1].txEnable <= 1;
      cyc;
      chk({pins[0].txPin, pins[0].rxToCore, hold}, 6'h21);
      chk(pins[1].txPin, 1'b0);
      cyc;
      cyc;
      chk(pins[1].rxToCore, 1'b0);
      $display("rts and loop tests done");
      for (int i = 0; i < NUM_CH; i++) begin
         @(posedge sys_clk) ctrl[i].rxHasData <= 1;
         ctrl[i].txHasSpace <= 1;
         cyc;
         chk({rxN, txN}, 2'h0);
         @(posedge sys_clk) ctrl[i].rxHasData <= 0;
         ctrl[i].txHasSpace <= 0;
         cyc;
         chk({rxN, txN}, 2'h3);
      end
      $display("ready tests done");
      acc(1, 1, 1, 5'h13, 1, 0, 5'h13);
      acc(1, 1, 0, 5'h0a, 0, 1, 5'h0a);
      acc(0, 1, 1, 5'h05, 0, 0, 5'h05);
      acc(1, 0, 0, 5'h1f, 0, 0, 5'h05);
      $display("host tests done");
      give_verdict;
   end
endmodule // test_quad_uart_pins
bind quad_uart_pins quad_uart_pins_assertions #(.CHANNELS(CHANNELS)) chk_u (.sys_clk(sys_clk),
   .rst_n(rst_n), .clkEn(clkEn), .altHostMode(altHostMode), .hostRdStrobe(hostRdStrobe),
   .hostWrStrobe(hostWrStrobe), .rx_ready_combined_n(rx_ready_combined_n),
   .tx_ready_combined_n(tx_ready_combined_n), .hostReq(hostReq), .chanCtrl(chanCtrl),
   .chanPins(chanPins), .autoRtsHold(autoRtsHold));
